// ===== verilog/stm_pkg.sv
package stm_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_SPEED = 8'h08;
  localparam logic [7:0] A_ACCEL = 8'h0C;
  localparam logic [7:0] A_TRAVEL = 8'h10;
  localparam logic [7:0] A_DOFORCE = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_IRQ_STAT = 8'h1C;
  localparam logic [7:0] A_IRQ_MASK = 8'h20;
  localparam logic [7:0] A_PSEL = 8'h24;
  localparam logic [7:0] A_PDATA = 8'h28;
  localparam logic [7:0] A_PROG = 8'h2C;
  localparam logic [15:0] SPEED_RST = 16'h00C8;
  localparam logic [15:0] SPEED_MAX = 16'h1770;
  localparam logic [15:0] ACCEL_RST = 16'h03E8;
  localparam logic [15:0] ACCEL_MIN = 16'h0001;
  localparam logic [15:0] JOG_ACC_MAX = 16'h4E20;
  localparam logic [15:0] POS_ACC_MAX = 16'hC350;
  localparam logic [23:0] TRAVEL_RST = 24'h01_86A0;
  localparam logic [23:0] TRAVEL_MAX = 24'h98_967F;
  localparam logic [1:0] PROG_LAST_RST = 2'h1;
  localparam logic [15:0] ACC_0000 = 16'h0000;
  localparam logic [15:0] ACC_000A = 16'h000A;
  localparam logic [15:0] ACC_000C = 16'h000C;
  localparam logic [15:0] ACC_000E = 16'h000E;
  localparam logic [15:0] ACC_000F = 16'h000F;
  localparam logic [15:0] ACC_100E = 16'h100E;
  localparam logic [6:0] P_FIRST = 7'h01;
  localparam logic [6:0] P_BASIC_HI = 7'h0B;
  localparam logic [6:0] P_ADJ_HI = 7'h1A;
  localparam logic [6:0] P_ACCESS = 7'h28;
  localparam logic [6:0] P_ALL_HI = 7'h4B;
  localparam logic [7:0] AL_ENC1 = 8'h16;
  localparam logic [7:0] AL_ENC2 = 8'h20;
  localparam logic [7:0] AL_ABS = 8'h25;
  localparam logic [7:0] WN_BATC = 8'h92;
  localparam logic [7:0] WN_BAT = 8'h9F;
  localparam logic [3:0] SW_TEST_PC = 4'hF;
  localparam logic [3:0] SW_TEST = 4'h0;
  localparam logic [3:0] SW_AXIS_MAX = 4'h8;
  localparam logic [15:0] SIM_TORQUE = 16'h0000;
  localparam logic [15:0] SIM_INERTIA_X10 = 16'h000A;
  localparam int CMD_FWD = 0;
  localparam int CMD_REV = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_START = 3;
  localparam int CMD_RESET = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_HALT = 1;
  localparam int IRQ_DENY = 2;
  localparam int IRQ_LINK = 3;
  localparam int IRQ_W = 4;
  typedef enum logic [2:0] {
    MD_OFF = 3'b000,
    MD_JOG = 3'b001,
    MD_POS = 3'b010,
    MD_PROG = 3'b011,
    MD_MLESS = 3'b100,
    MD_DO = 3'b101
  } stm_mode_t;
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_PAUSE = 3'b011,
    ST_HALT = 3'b100
  } stm_state_t;
endpackage

// ===== verilog/stm_ramp.sv
`timescale 1ns/1ps
module stm_ramp (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic halt_i,
  input wire logic load_i,
  input wire logic limited_i,
  input wire logic [15:0] target_i,
  input wire logic [15:0] accel_i,
  input wire logic [23:0] travel_i,
  output logic [15:0] speed_o,
  output logic [23:0] remain_o,
  output logic done_o
);
  typedef struct packed {
    logic [15:0] speed;
    logic [15:0] acc;
    logic [23:0] remain;
    logic done;
  } stm_ramp_st_t;
  stm_ramp_st_t q_r, q_nxt;
  logic [16:0] sum;

  // One speed step per tick whenever target/accel accumulates past accel
  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    sum = {1'b0, q_r.acc} + {1'b0, target_i};
    if (halt_i) begin
      q_nxt.speed = '0;
      q_nxt.acc = '0;
      q_nxt.done = q_r.speed != '0;
    end else if (load_i) begin
      q_nxt.remain = travel_i;
      q_nxt.acc = '0;
    end else if (tick_i) begin
      if (sum >= {1'b0, accel_i}) begin
        q_nxt.acc = 16'(sum - {1'b0, accel_i});
        if (run_i && q_r.speed < target_i) begin
          q_nxt.speed = q_r.speed + 16'h0001;
        end else if ((!run_i || q_r.speed > target_i) && q_r.speed != '0) begin
          q_nxt.speed = q_r.speed - 16'h0001;
          q_nxt.done = !run_i && q_r.speed == 16'h0001;
        end
      end else begin
        q_nxt.acc = sum[15:0];
      end
      // Limitation: a positioning move stops at the target without a decel tail
      if (limited_i && q_r.speed != '0) begin
        if (q_r.remain <= {8'h00, q_r.speed}) begin
          q_nxt.remain = '0;
          q_nxt.speed = '0;
          q_nxt.done = 1'b1;
        end else begin
          q_nxt.remain = q_r.remain - {8'h00, q_r.speed};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign speed_o = q_r.speed;
  assign remain_o = q_r.remain;
  assign done_o = q_r.done;
endmodule

// ===== verilog/stm_top.sv
// Operation
// RQ1 - Jog needs no controller; halt must be released.
// RQ2 - Jog speed 200; accel 1000 ms, 1 to 20000.
// RQ3 - Jog commands: forward, reverse, stop.
// RQ4 - Travel 100000, max 9999999; accel to 50000; fwd, rev, pause.
// RQ5 - Program runs patterns in turn; start begins, reset stops.
// RQ6 - Motor-less answers the controller as if a motor turned.
// RQ7 - Motor-less torque zero, inertia the motor's own.
// RQ8 - Motor-less hides alarms 16, 20, 25, warnings 92, 9F.
// RQ9 - Forced-output drives outputs as the host says.
// RQ10 - Host tests need switch F at power-up.
// RQ11 - Controller values win after a power cycle.
// RQ12 - Groups 1-11, 12-26, 27-40; basic writable by default.
// RQ13 - New access setting acts after a power cycle.
// RQ14 - Host access per setting; controller reaches 1-75.
// RQ15 - Starred values lock at link-up.
// RQ16 - Reserved parameters get initial values only.
// RQ17 - Switch 0 is test mode; 1 to 8 pick axes.
// RQ18 - Halt aborts motion; restart needs release and new start.
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module stm_top #(
  parameter int unsigned TICK_CYC = stm_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic pwr_restart_i,
  input wire logic [3:0] axis_select_switch_i,
  input wire logic emergency_halt_input_i,
  input wire logic ctrl_link_i,
  input wire logic ctrl_par_we_i,
  input wire logic [6:0] ctrl_par_num_i,
  input wire logic [15:0] ctrl_par_dat_i,
  output logic [15:0] ctrl_par_dat_o,
  input wire logic [15:0] ctrl_speed_cmd_i,
  input wire logic alarm_vld_i,
  input wire logic [7:0] alarm_code_i,
  output logic alarm_vld_o,
  output logic [7:0] alarm_code_o,
  input wire logic [7:0] do_norm_i,
  output logic [7:0] do_o,
  output logic [15:0] motor_speed_o,
  output logic motor_dir_o,
  output logic [15:0] sim_speed_o,
  output logic [15:0] sim_torque_o,
  output logic [15:0] sim_inertia_o,
  output logic [3:0] axis_id_o,
  output logic test_en_o
);
  localparam int TW = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    stm_pkg::stm_mode_t mode;
    logic [1:0] prog_last;
    logic [15:0] speed;
    logic [15:0] accel;
    logic [23:0] travel;
    logic [7:0] do_force;
    logic [stm_pkg::IRQ_W-1:0] irq_stat;
    logic [stm_pkg::IRQ_W-1:0] irq_mask;
    logic [6:0] psel;
    logic [3:0][24:0] prog;
    stm_pkg::stm_state_t st;
    logic cold;
    logic [6:0] boot_idx;
    logic [3:0] sw;
    logic [15:0] acc_eff;
    logic lock;
    logic link_d;
    logic run;
    logic dir;
    logic limited;
    logic load;
    logic [1:0] pidx;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [7:0] do_out;
    logic alarm_vld;
    logic [7:0] alarm_code;
    logic [15:0] sim_speed;
  } stm_st_t;

  stm_st_t q_r, q_nxt;
  logic [15:0] par_mem [1:75];
  logic [15:0] shadow_mem [1:75];
  logic host_we;
  logic [15:0] host_d;
  logic [15:0] cur_speed;
  logic move_done;

  function automatic logic in_rng(input logic [6:0] n, input logic [6:0] lo,
                                  input logic [6:0] hi);
    return n >= lo && n <= hi;
  endfunction

  function automatic logic host_rd_ok(input logic [15:0] acc, input logic [6:0] n); // RQ12
    unique case (acc)
      stm_pkg::ACC_000A: return n == stm_pkg::P_ACCESS;
      stm_pkg::ACC_000C, stm_pkg::ACC_000E, stm_pkg::ACC_100E:
        return in_rng(n, stm_pkg::P_FIRST, stm_pkg::P_ACCESS);
      stm_pkg::ACC_000F: return in_rng(n, stm_pkg::P_FIRST, stm_pkg::P_ALL_HI);
      default: return in_rng(n, stm_pkg::P_FIRST, stm_pkg::P_BASIC_HI) || n == stm_pkg::P_ACCESS;
    endcase
  endfunction

  function automatic logic host_wr_ok(input logic [15:0] acc, input logic [6:0] n);
    unique case (acc)
      stm_pkg::ACC_000A, stm_pkg::ACC_100E: return n == stm_pkg::P_ACCESS;
      stm_pkg::ACC_000E: return in_rng(n, stm_pkg::P_FIRST, stm_pkg::P_ACCESS);
      stm_pkg::ACC_000F: return in_rng(n, stm_pkg::P_FIRST, stm_pkg::P_ALL_HI);
      default: return in_rng(n, stm_pkg::P_FIRST, stm_pkg::P_BASIC_HI) || n == stm_pkg::P_ACCESS;
    endcase
  endfunction

  // Parameters that, once the controller has linked up, take a new value only across a power cycle
  function automatic logic is_star(input logic [6:0] n);
    return n == 7'h01 || n == 7'h02 || n == 7'h06 || n == 7'h07 ||
           n == 7'h17 || n == 7'h18 || n == 7'h21;
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  logic req;
  logic wr;
  logic [31:0] wv;
  logic test_ok;
  logic mless_ok;
  logic [15:0] acc_use;
  logic [15:0] par_rd;
  logic [4:0] cmd;
  logic [stm_pkg::IRQ_W-1:0] ev;
  logic [31:0] rd;

  assign req = wb_cyc_i && wb_stb_i && !q_r.ack;
  assign wr = req && wb_we_i;
  assign test_ok = q_r.sw == stm_pkg::SW_TEST_PC; // RQ10
  assign mless_ok = ctrl_link_i && (test_ok || q_r.sw == stm_pkg::SW_TEST); // RQ17
  assign par_rd = in_rng(q_r.psel, stm_pkg::P_FIRST, stm_pkg::P_ALL_HI) ?
                  par_mem[q_r.psel] : 16'h0000;
  // Jog keeps its own narrower accel ceiling on a shared register
  assign acc_use = (q_r.mode == stm_pkg::MD_JOG && q_r.accel > stm_pkg::JOG_ACC_MAX) ?
                   stm_pkg::JOG_ACC_MAX : q_r.accel; // RQ2

  always_comb begin
    q_nxt = q_r;
    ev = '0;
    host_we = 1'b0;
    host_d = wb_dat_i[15:0];
    wv = '0;
    rd = '0;
    cmd = '0;
    q_nxt.ack = req;
    q_nxt.load = 1'b0;
    q_nxt.link_d = ctrl_link_i;
    q_nxt.tick = 1'b0;
    if (q_r.tick_cnt == TW'(TICK_CYC - 1)) begin
      q_nxt.tick_cnt = '0;
      q_nxt.tick = 1'b1;
    end else begin
      q_nxt.tick_cnt = q_r.tick_cnt + TW'(1);
    end
    if (ctrl_link_i && !q_r.link_d && q_r.st != stm_pkg::ST_BOOT) begin
      q_nxt.lock = 1'b1; // RQ15
      ev[stm_pkg::IRQ_LINK] = 1'b1;
    end
    if (req) begin
      unique case (wb_adr_i)
        stm_pkg::A_CTRL: rd = {26'h0, q_r.prog_last, 1'b0, q_r.mode};
        stm_pkg::A_SPEED: rd = {16'h0, q_r.speed};
        stm_pkg::A_ACCEL: rd = {16'h0, q_r.accel};
        stm_pkg::A_TRAVEL: rd = {8'h0, q_r.travel};
        stm_pkg::A_DOFORCE: rd = {24'h0, q_r.do_force};
        stm_pkg::A_STATUS: rd = {q_r.acc_eff, 2'h0, q_r.sw, q_r.lock,
                                 emergency_halt_input_i, test_ok, q_r.dir,
                                 q_r.run, q_r.pidx, q_r.st};
        stm_pkg::A_IRQ_STAT: rd = {28'h0, q_r.irq_stat};
        stm_pkg::A_IRQ_MASK: rd = {28'h0, q_r.irq_mask};
        stm_pkg::A_PSEL: rd = {25'h0, q_r.psel};
        stm_pkg::A_PDATA: rd = host_rd_ok(q_r.acc_eff, q_r.psel) ? {16'h0, par_rd} : '0; // RQ14
        default: rd = '0;
      endcase
      q_nxt.rdat = rd;
      if (!wb_we_i && wb_adr_i == stm_pkg::A_PDATA && !host_rd_ok(q_r.acc_eff, q_r.psel))
        ev[stm_pkg::IRQ_DENY] = 1'b1;
    end
    if (wr) begin
      wv = wmask(rd, wb_dat_i, wb_sel_i);
      unique case (wb_adr_i)
        stm_pkg::A_CTRL: begin
          q_nxt.prog_last = wv[5:4];
          // Mode changes only between moves; off is always allowed, other modes only where the switch allows
          if (q_r.st == stm_pkg::ST_IDLE &&
              (wv[2:0] == stm_pkg::MD_OFF ||
               (wv[2:0] == stm_pkg::MD_MLESS && mless_ok) ||
               (wv[2:0] != stm_pkg::MD_MLESS && wv[2:0] <= stm_pkg::MD_DO && test_ok)))
            q_nxt.mode = stm_pkg::stm_mode_t'(wv[2:0]); // RQ10
          else if (wv[2:0] != q_r.mode)
            ev[stm_pkg::IRQ_DENY] = 1'b1;
        end
        stm_pkg::A_CMD: cmd = wv[4:0];
        stm_pkg::A_SPEED: q_nxt.speed = wv[15:0] > stm_pkg::SPEED_MAX ?
                                        stm_pkg::SPEED_MAX : wv[15:0]; // RQ2
        stm_pkg::A_ACCEL: begin
          if (wv[15:0] >= stm_pkg::ACCEL_MIN && wv[15:0] <= stm_pkg::POS_ACC_MAX)
            q_nxt.accel = wv[15:0]; // RQ4
          else
            ev[stm_pkg::IRQ_DENY] = 1'b1;
        end
        stm_pkg::A_TRAVEL: begin
          if (wv[23:0] <= stm_pkg::TRAVEL_MAX)
            q_nxt.travel = wv[23:0]; // RQ4
          else
            ev[stm_pkg::IRQ_DENY] = 1'b1;
        end
        stm_pkg::A_DOFORCE: q_nxt.do_force = wv[7:0];
        stm_pkg::A_IRQ_STAT: q_nxt.irq_stat = q_r.irq_stat & ~wv[stm_pkg::IRQ_W-1:0];
        stm_pkg::A_IRQ_MASK: q_nxt.irq_mask = wv[stm_pkg::IRQ_W-1:0];
        stm_pkg::A_PSEL: q_nxt.psel = wv[6:0];
        stm_pkg::A_PDATA: begin
          host_d = wv[15:0];
          if (host_wr_ok(q_r.acc_eff, q_r.psel) && q_r.st != stm_pkg::ST_BOOT &&
              !(is_star(q_r.psel) && q_r.lock))
            host_we = 1'b1; // RQ14
          else
            ev[stm_pkg::IRQ_DENY] = 1'b1;
        end
        stm_pkg::A_PROG: q_nxt.prog[wv[27:26]] = wv[24:0];
        default: ;
      endcase
    end
    unique case (q_r.st)
      stm_pkg::ST_BOOT: begin
        q_nxt.boot_idx = q_r.boot_idx + 7'h01;
        if (q_r.boot_idx == stm_pkg::P_ALL_HI) begin
          q_nxt.st = stm_pkg::ST_IDLE;
          q_nxt.acc_eff = q_r.cold ? stm_pkg::ACC_0000 : shadow_mem[stm_pkg::P_ACCESS]; // RQ13
          q_nxt.sw = axis_select_switch_i;
          q_nxt.cold = 1'b0;
        end
      end
      stm_pkg::ST_IDLE: begin
        if (!emergency_halt_input_i && test_ok) begin // RQ1
          if ((q_r.mode == stm_pkg::MD_JOG || q_r.mode == stm_pkg::MD_POS) &&
              (cmd[stm_pkg::CMD_FWD] || cmd[stm_pkg::CMD_REV])) begin
            q_nxt.st = stm_pkg::ST_RUN; // RQ3
            q_nxt.run = 1'b1;
            q_nxt.load = 1'b1;
            q_nxt.dir = cmd[stm_pkg::CMD_REV];
            q_nxt.limited = q_r.mode == stm_pkg::MD_POS; // RQ4
          end else if (q_r.mode == stm_pkg::MD_PROG && cmd[stm_pkg::CMD_START]) begin
            q_nxt.st = stm_pkg::ST_RUN; // RQ5
            q_nxt.run = 1'b1;
            q_nxt.load = 1'b1;
            q_nxt.limited = 1'b1;
            q_nxt.pidx = 2'h0;
            q_nxt.dir = q_r.prog[0][24];
          end
        end
      end
      stm_pkg::ST_RUN: begin
        if (emergency_halt_input_i) begin
          q_nxt.st = stm_pkg::ST_HALT; // RQ18
          q_nxt.run = 1'b0;
          ev[stm_pkg::IRQ_HALT] = 1'b1;
        end else if (move_done) begin
          if (q_r.mode == stm_pkg::MD_PROG && q_r.run && q_r.pidx != q_r.prog_last) begin
            q_nxt.pidx = q_r.pidx + 2'h1; // RQ5
            q_nxt.dir = q_r.prog[q_r.pidx + 2'h1][24];
            q_nxt.load = 1'b1;
          end else begin
            q_nxt.st = stm_pkg::ST_IDLE;
            q_nxt.run = 1'b0;
            ev[stm_pkg::IRQ_DONE] = 1'b1;
          end
        end else if (q_r.mode == stm_pkg::MD_POS && cmd[stm_pkg::CMD_STOP]) begin
          q_nxt.st = stm_pkg::ST_PAUSE; // RQ4
          q_nxt.run = 1'b0;
        end else if ((q_r.mode == stm_pkg::MD_JOG && cmd[stm_pkg::CMD_STOP]) ||
                     (q_r.mode == stm_pkg::MD_PROG && cmd[stm_pkg::CMD_RESET])) begin
          q_nxt.run = 1'b0; // RQ3 RQ5
          if (cur_speed == '0)
            q_nxt.st = stm_pkg::ST_IDLE;
        end
      end
      stm_pkg::ST_PAUSE: begin
        if (emergency_halt_input_i) begin
          q_nxt.st = stm_pkg::ST_HALT; // RQ18
          ev[stm_pkg::IRQ_HALT] = 1'b1;
        end else if (cmd[stm_pkg::CMD_FWD] || cmd[stm_pkg::CMD_REV]) begin
          q_nxt.st = stm_pkg::ST_RUN;
          q_nxt.run = 1'b1;
          q_nxt.dir = cmd[stm_pkg::CMD_REV];
        end
      end
      stm_pkg::ST_HALT: begin
        if (!emergency_halt_input_i)
          q_nxt.st = stm_pkg::ST_IDLE; // RQ18
      end
      default: q_nxt.st = stm_pkg::ST_IDLE;
    endcase
    // A restored supply replays the boot copy; host parameter values are lost except the access setting (40)
    if (pwr_restart_i) begin
      q_nxt.st = stm_pkg::ST_BOOT; // RQ11
      q_nxt.boot_idx = stm_pkg::P_FIRST;
      q_nxt.lock = 1'b0;
      q_nxt.run = 1'b0;
      q_nxt.mode = stm_pkg::MD_OFF;
    end
    q_nxt.do_out = q_r.mode == stm_pkg::MD_DO ? q_r.do_force : do_norm_i; // RQ9
    q_nxt.alarm_code = alarm_code_i;
    q_nxt.alarm_vld = alarm_vld_i && !(q_r.mode == stm_pkg::MD_MLESS &&
      (alarm_code_i == stm_pkg::AL_ENC1 || alarm_code_i == stm_pkg::AL_ENC2 ||
       alarm_code_i == stm_pkg::AL_ABS || alarm_code_i == stm_pkg::WN_BATC ||
       alarm_code_i == stm_pkg::WN_BAT)); // RQ8
    q_nxt.sim_speed = q_r.mode == stm_pkg::MD_MLESS ? ctrl_speed_cmd_i : 16'h0000; // RQ6
    // Set wins over a same-cycle write-one clear
    q_nxt.irq_stat = q_nxt.irq_stat | ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;
      q_r.st <= stm_pkg::ST_BOOT;
      q_r.cold <= 1'b1;
      q_r.boot_idx <= stm_pkg::P_FIRST;
      q_r.mode <= stm_pkg::MD_OFF;
      q_r.prog_last <= stm_pkg::PROG_LAST_RST;
      q_r.speed <= stm_pkg::SPEED_RST;
      q_r.accel <= stm_pkg::ACCEL_RST;
      q_r.travel <= stm_pkg::TRAVEL_RST;
      q_r.acc_eff <= stm_pkg::ACC_0000;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Non-volatile shadow holds controller values across a power cycle
  always_ff @(posedge clk_i) begin
    if (q_r.st == stm_pkg::ST_BOOT && q_r.boot_idx <= stm_pkg::P_ALL_HI) begin
      par_mem[q_r.boot_idx] <= q_r.cold ? 16'h0000 : shadow_mem[q_r.boot_idx]; // RQ11
      if (q_r.cold)
        shadow_mem[q_r.boot_idx] <= 16'h0000;
    end
    if (host_we) begin
      par_mem[q_r.psel] <= host_d;
      if (q_r.psel == stm_pkg::P_ACCESS)
        shadow_mem[q_r.psel] <= host_d; // RQ13
    end
    if (ctrl_par_we_i && in_rng(ctrl_par_num_i, stm_pkg::P_FIRST, stm_pkg::P_ALL_HI)) begin
      shadow_mem[ctrl_par_num_i] <= ctrl_par_dat_i; // RQ14
      if (!(is_star(ctrl_par_num_i) && q_r.lock) && ctrl_par_num_i != stm_pkg::P_ACCESS)
        par_mem[ctrl_par_num_i] <= ctrl_par_dat_i; // RQ15
    end
  end

  stm_ramp u_ramp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(q_r.tick),
    .run_i(q_r.run && q_r.st == stm_pkg::ST_RUN),
    .halt_i(emergency_halt_input_i || pwr_restart_i),
    .load_i(q_r.load),
    .limited_i(q_r.limited),
    .target_i(q_r.speed),
    .accel_i(acc_use),
    .travel_i(q_r.mode == stm_pkg::MD_PROG ? q_r.prog[q_r.pidx][23:0] : q_r.travel),
    .speed_o(cur_speed),
    .remain_o(),
    .done_o(move_done)
  );

  assign wb_ack_o = q_r.ack;
  assign wb_dat_o = q_r.rdat;
  assign irq_o = |(q_r.irq_stat & q_r.irq_mask);
  assign ctrl_par_dat_o = in_rng(ctrl_par_num_i, stm_pkg::P_FIRST, stm_pkg::P_ALL_HI) ?
                          par_mem[ctrl_par_num_i] : 16'h0000;
  assign do_o = q_r.do_out;
  assign alarm_vld_o = q_r.alarm_vld;
  assign alarm_code_o = q_r.alarm_code;
  assign motor_speed_o = cur_speed;
  assign motor_dir_o = q_r.dir;
  assign sim_speed_o = q_r.sim_speed;
  assign sim_torque_o = stm_pkg::SIM_TORQUE; // RQ7
  assign sim_inertia_o = stm_pkg::SIM_INERTIA_X10; // RQ7
  assign axis_id_o = (q_r.sw <= stm_pkg::SW_AXIS_MAX) ? q_r.sw : 4'h0; // RQ17
  assign test_en_o = test_ok;
endmodule

// ===== tb/stm_props.sv
`timescale 1ns/1ps
module stm_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic alarm_vld_i,
  input wire logic [7:0] alarm_code_i,
  input wire logic alarm_vld_o,
  input wire logic [7:0] alarm_code_o,
  input wire logic emergency_halt_input_i,
  input wire logic [15:0] motor_speed_o,
  input wire logic [15:0] sim_torque_o,
  input wire logic [15:0] sim_inertia_o,
  input wire logic [3:0] axis_id_o,
  input wire logic test_en_o,
  input wire logic [6:0] ctrl_par_num_i,
  input wire logic [15:0] ctrl_par_dat_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic hid = alarm_code_i inside {8'h16, 8'h20, 8'h25, 8'h92, 8'h9F};
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_torque_zero: assert property (sim_torque_o == 16'h0000)
    else $error("load torque not zero");
  a_inertia_motor: assert property (sim_inertia_o == 16'h000A)
    else $error("inertia ratio wrong");
  a_alarm_pass: assert property (alarm_vld_i && !hid |=>
    alarm_vld_o && alarm_code_o == $past(alarm_code_i)) else $error("alarm lost");
  a_halt_stop: assert property (emergency_halt_input_i |=> motor_speed_o == 16'h0000)
    else $error("motion during forced stop");
  a_axis_range: assert property (axis_id_o <= 4'h8)
    else $error("axis out of range");
  a_test_axis: assert property (test_en_o |-> axis_id_o == 4'h0)
    else $error("test mode with axis");
  a_ctrl_range: assert property (ctrl_par_num_i == 7'h00 || ctrl_par_num_i > 7'h4B
    |-> ctrl_par_dat_o == 16'h0000) else $error("param outside range read");
  c_ack: cover property (wb_ack_o);
  c_halt: cover property (emergency_halt_input_i);
  c_hide: cover property (alarm_vld_i && hid);
endmodule
bind stm_top stm_props u_props (.*);

// ===== tb/stm_ctrl_model.sv
`timescale 1ns/1ps
module stm_ctrl_model (
  input wire logic clk_i,
  output logic link_o = 1'b0,
  output logic we_o = 1'b0,
  output logic [6:0] num_o = 7'h00,
  output logic [15:0] dat_o = '0,
  output logic [15:0] speed_o = '0,
  output logic alm_vld_o = 1'b0,
  output logic [7:0] alm_code_o = 8'h00
);
  task automatic up();
    @(posedge clk_i);
    link_o <= 1'b1;
  endtask
  task automatic par(input logic [6:0] n, input logic [15:0] d);
    @(posedge clk_i);
    {we_o, num_o, dat_o} <= {1'b1, n, d};
    @(posedge clk_i);
    {we_o, dat_o} <= {1'b0, ~d};
  endtask
  task automatic spd(input logic [15:0] v);
    @(posedge clk_i);
    speed_o <= v;
  endtask
  task automatic alarm(input logic [7:0] c);
    @(posedge clk_i);
    {alm_vld_o, alm_code_o} <= {1'b1, c};
    @(posedge clk_i);
    {alm_vld_o, alm_code_o} <= {1'b0, ~c};
  endtask
endmodule

// ===== tb/servo_test_mode_param_guard_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("Error %0t: value mismatch", $time); end end
module servo_test_mode_param_guard_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic pwr_restart_i = 1'b0, emergency_halt_input_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, do_norm_i = 8'hA5, alarm_code_i, do_o, alarm_code_o;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, r;
  logic [3:0] axis_select_switch_i = 4'hF, axis_id_o;
  logic wb_ack_o, irq_o, alarm_vld_o, alarm_vld_i, ctrl_link_i, ctrl_par_we_i;
  logic motor_dir_o, test_en_o;
  logic [6:0] ctrl_par_num_i;
  logic [15:0] ctrl_par_dat_i, ctrl_par_dat_o, ctrl_speed_cmd_i, motor_speed_o, sim_speed_o;
  logic [31:0] exq[$], mq[$];
  logic [7:0] codes [6] = '{8'h16, 8'h20, 8'h25, 8'h92, 8'h9F, 8'h31};
  int n_errors = 0, check_count = 0;
  stm_top #(.TICK_CYC(20)) dut (.*, .wb_sel_i(4'hF), .sim_torque_o(), .sim_inertia_o());
  stm_ctrl_model cm (.clk_i, .link_o(ctrl_link_i), .we_o(ctrl_par_we_i),
    .num_o(ctrl_par_num_i), .dat_o(ctrl_par_dat_i), .speed_o(ctrl_speed_cmd_i),
    .alm_vld_o(alarm_vld_i), .alm_code_o(alarm_code_i));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, e, m);
    int n;
    n = 0;
    if (!w) begin
      exq.push_back(e);
      mq.push_back(m);
    end
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
    if (n >= 50) n_errors++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, '0, '0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    wb(1'b0, a, '0, e, m);
  endtask
  task automatic wait_irq();
    for (int n = 0; n < 8000 && irq_o !== 1'b1; n++) @(posedge clk_i);
  endtask
  task automatic restart();
    @(posedge clk_i);
    pwr_restart_i <= 1'b1;
    @(posedge clk_i);
    pwr_restart_i <= 1'b0;
    repeat (80) @(posedge clk_i);
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exq.size() > 0) begin
      r = mq.pop_front();
      `CHK(wb_dat_o & r, exq.pop_front() & r)
    end
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
  initial begin
    r = $urandom(2);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (80) @(posedge clk_i);
    `CHK({test_en_o, axis_id_o}, 5'h10)
    rd(stm_pkg::A_SPEED, 32'hC8, 32'hFFFF);
    rd(stm_pkg::A_ACCEL, 32'h3E8, 32'hFFFF);
    rd(stm_pkg::A_TRAVEL, 32'h1_86A0, 32'hFF_FFFF);
    rd(8'h3C, '0, '1);
    wr(stm_pkg::A_IRQ_MASK, 32'h7);
    wr(stm_pkg::A_ACCEL, '0);
    rd(stm_pkg::A_ACCEL, 32'h3E8, 32'hFFFF);
    `CHK(irq_o, 1'b1)
    wr(stm_pkg::A_IRQ_STAT, 32'hF);
    `CHK(irq_o, 1'b0)
    r = $urandom_range(6000, 1);
    wr(stm_pkg::A_SPEED, r);
    rd(stm_pkg::A_SPEED, r, 32'hFFFF);
    wr(stm_pkg::A_ACCEL, 32'h1);
    wr(stm_pkg::A_CTRL, 32'h1);
    wr(stm_pkg::A_CMD, 32'h1);
    repeat (300) @(posedge clk_i);
    `CHK({motor_speed_o != 16'h0000, motor_dir_o}, 2'b10)
    emergency_halt_input_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(stm_pkg::A_STATUS, 32'h104, 32'h107);
    emergency_halt_input_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(stm_pkg::A_STATUS, 32'h1, 32'h7);
    repeat (100) @(posedge clk_i);
    `CHK(motor_speed_o, 16'h0000)
    wr(stm_pkg::A_IRQ_STAT, 32'hF);
    wr(stm_pkg::A_CMD, 32'h2);
    repeat (300) @(posedge clk_i);
    `CHK(motor_dir_o, 1'b1)
    wr(stm_pkg::A_CMD, 32'h4);
    wait_irq();
    `CHK(irq_o, 1'b1)
    wr(stm_pkg::A_CTRL, 32'h2);
    wr(stm_pkg::A_TRAVEL, 32'h98_9680);
    rd(stm_pkg::A_TRAVEL, 32'h1_86A0, 32'hFF_FFFF);
    wr(stm_pkg::A_ACCEL, 32'hC350);
    rd(stm_pkg::A_ACCEL, 32'hC350, 32'hFFFF);
    wr(stm_pkg::A_ACCEL, 32'h1);
    wr(stm_pkg::A_TRAVEL, 32'h32);
    wr(stm_pkg::A_IRQ_STAT, 32'hF);
    wr(stm_pkg::A_CMD, 32'h1);
    wait_irq();
    `CHK({irq_o, motor_speed_o}, 17'h1_0000)
    cm.up();
    cm.par(7'h0C, 16'h1234);
    cm.par(7'h05, 16'h0033);
    cm.par(7'h3C, 16'h0BEE);
    @(negedge clk_i);
    `CHK(ctrl_par_dat_o, 16'h0BEE)
    wr(stm_pkg::A_PSEL, 32'h5);
    wr(stm_pkg::A_PDATA, 32'h55);
    rd(stm_pkg::A_PDATA, 32'h55, 32'hFFFF);
    wr(stm_pkg::A_PSEL, 32'hC);
    rd(stm_pkg::A_PDATA, '0, 32'hFFFF);
    wr(stm_pkg::A_PSEL, 32'h28);
    wr(stm_pkg::A_PDATA, 32'hF);
    wr(stm_pkg::A_PSEL, 32'hC);
    rd(stm_pkg::A_PDATA, '0, 32'hFFFF);
    restart();
    rd(stm_pkg::A_STATUS, 32'hF_0000, 32'hFFFF_0000);
    rd(stm_pkg::A_PDATA, 32'h1234, 32'hFFFF);
    wr(stm_pkg::A_PSEL, 32'h5);
    rd(stm_pkg::A_PDATA, 32'h33, 32'hFFFF);
    wr(stm_pkg::A_CTRL, 32'h4);
    r = $urandom;
    cm.spd(r[15:0]);
    repeat (5) @(posedge clk_i);
    `CHK(sim_speed_o, r[15:0])
    for (int i = 0; i < 6; i++) begin
      cm.alarm(codes[i]);
      @(negedge clk_i);
      `CHK(alarm_vld_o, i == 5)
    end
    wr(stm_pkg::A_CTRL, 32'h5);
    r = $urandom;
    wr(stm_pkg::A_DOFORCE, r);
    repeat (3) @(posedge clk_i);
    `CHK(do_o, r[7:0])
    axis_select_switch_i <= 4'h3;
    wr(stm_pkg::A_IRQ_STAT, 32'hF);
    restart();
    `CHK({test_en_o, axis_id_o}, 5'h03)
    wr(stm_pkg::A_CTRL, 32'h1);
    rd(stm_pkg::A_CTRL, '0, 32'h7);
    `CHK(irq_o, 1'b1)
    stop_test();
  end
endmodule
